// *** inc/rtcp_consts.vh ***
// Purpose: Register offsets, field positions, reset values and timing counts of the counter block.
// Assumes: Byte-wide register port, one clock.
// Notes: Counter-domain ticks arrive as enables on the main clock.
`ifndef RTCP_CONSTS_VH
`define RTCP_CONSTS_VH
`define RTCP_OFS_STATUS 5'h01
`define RTCP_OFS_FLAGS 5'h03
`define RTCP_OFS_CTRL 5'h00
`define RTCP_OFS_DBG 5'h05
`define RTCP_OFS_CLOCK_SOURCE_SELECT 5'h07
`define RTCP_OFS_TICK_L 5'h08
`define RTCP_OFS_TICK_H 5'h09
`define RTCP_OFS_WRAP_L 5'h0A
`define RTCP_OFS_WRAP_H 5'h0B
`define RTCP_OFS_MATCH_L 5'h0C
`define RTCP_OFS_MATCH_H 5'h0D
`define RTCP_OFS_PCTRL 5'h10
`define RTCP_OFS_PSTAT 5'h11
`define RTCP_OFS_PIEN 5'h12
`define RTCP_OFS_PFLAG 5'h13
`define RTCP_OFS_PDBG 5'h15
`define RTCP_TICK_RST 16'h0000
`define RTCP_WRAP_RST 16'hFFFF
`define RTCP_MATCH_RST 16'h0000
`define RTCP_SRC_FAST 2'h0
`define RTCP_SRC_SLOW 2'h1
`define RTCP_SRC_XTAL 2'h2
`define RTCP_SRC_PIN 2'h3
`define RTCP_SLOW_DIV 5'h1F
`define RTCP_SYNC_TICKS 2'h2
`define RTCP_PER_OFF 4'h0
`define RTCP_PER_RSVD 4'hF
`define RTCP_CTRL_EN_BIT 0
`define RTCP_CTRL_PRE_LSB 3
`define RTCP_PCTRL_PER_LSB 3
`endif

// *** verilog/rtcp_counter.v ***
// Purpose: Real-time tick counter with wrap, match, prescaler and a periodic timer.
// Assumes: Counter-clock sources arrive as edges sampled on clk, far slower than clk.
// Notes: Tick, wrap, match and control writes reach the counter logic after two counter clock ticks.
`timescale 1ns/1ps
`include "rtcp_consts.vh"

// Function
// - Counter halts in debug unless override set
// - Source choice selects one of four clocks
// - Sixteen-bit values split into low, high bytes
// - Tick and wrap writes apply after two ticks
// - Tick value readable, writable, resets zero
// - Wrap limit readable, writable, resets ones
// - Match value readable, writable, resets zero
// - Interval code picks periodic spacing, zero off
// - Periodic timer runs only while enabled
// - Periodic busy while control write synchronizes
// - Periodic irq enable gates the request
// - Periodic flag sets per event, write-one clears
// - Periodic timer has own debug override
// - Tick reaching wrap restarts, sets wrap flag
// - Tick equal to match sets match flag
// - Prescaler divides counter clock by power two
// - Match busy while match value synchronizes
module rtcp_counter (
   input wire clk,
   input wire nrst,
   input wire [4:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire debug_halt,
   input wire low_power_oscillator,
   input wire crystal_input_pin,
   input wire external_pin_source,
   output wire periodic_irq,
   output wire wrap_irq_flag,
   output wire match_irq_flag
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg [7:0] ctrl_q;
   reg halt_override_q;
   reg [1:0] source_choice_q;
   reg [15:0] tick_sw_q;
   reg [15:0] wrap_sw_q;
   reg [15:0] match_sw_q;
   reg [7:0] pctrl_sw_q;
   reg periodic_irq_enable_q;
   reg periodic_debug_q;
   reg wrap_flag_q;
   reg match_flag_q;
   reg periodic_flag_q;

   // Values as seen by the counter logic after synchronization.
   reg [15:0] tick_q;
   reg [15:0] wrap_q;
   reg [15:0] match_q;
   reg [7:0] pctrl_q;

   reg [7:0] ctrl_act_q;

   // Tracker outputs per synchronized value: a landing strobe that is high
   // on the counter tick that applies the value, and the busy level that
   // software polls.
   wire tick_apply;
   wire tick_busy;
   wire wrap_apply;
   wire wrap_busy;
   wire match_apply;
   wire match_busy;
   wire pctrl_apply;
   wire pctrl_busy;
   wire ctrl_apply;
   wire ctrl_busy;

   wire wr_tick = wr && (addr == `RTCP_OFS_TICK_L || addr == `RTCP_OFS_TICK_H);
   wire wr_wrap = wr && (addr == `RTCP_OFS_WRAP_L || addr == `RTCP_OFS_WRAP_H);
   wire wr_match = wr && (addr == `RTCP_OFS_MATCH_L || addr == `RTCP_OFS_MATCH_H);
   wire wr_pctrl = wr && addr == `RTCP_OFS_PCTRL;
   wire wr_ctrl = wr && addr == `RTCP_OFS_CTRL;

   // ----------------------------------------------------------------
   // Counter clock source selection
   // ----------------------------------------------------------------
   reg [2:0] src_hist_q;
   reg [4:0] slow_div_q;
   reg src_sel;
   wire fast_edge = low_power_oscillator & ~src_hist_q[0];
   always @* begin
      case (source_choice_q)
         `RTCP_SRC_FAST: src_sel = fast_edge;
         `RTCP_SRC_SLOW: src_sel = fast_edge && slow_div_q == `RTCP_SLOW_DIV;
         `RTCP_SRC_XTAL: src_sel = crystal_input_pin & ~src_hist_q[1];
         `RTCP_SRC_PIN: src_sel = external_pin_source & ~src_hist_q[2];
         default: src_sel = 1'b0;
      endcase
   end
   wire ctick = src_sel;

   always @(posedge clk) begin
      if (!nrst) begin
         src_hist_q <= 3'h0;
         slow_div_q <= 5'h00;
      end else begin
         src_hist_q <= {external_pin_source, crystal_input_pin, low_power_oscillator};
         if (fast_edge) begin
            slow_div_q <= slow_div_q + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and debug gating
   // ----------------------------------------------------------------
   reg [14:0] pre_q;
   wire [3:0] pre_sel = ctrl_act_q[`RTCP_CTRL_PRE_LSB +: 4];
   wire [15:0] pre_mask = (16'h0001 << pre_sel) - 16'h0001;
   wire cnt_run = ctrl_act_q[`RTCP_CTRL_EN_BIT] && (halt_override_q || !debug_halt);
   wire cnt_step = cnt_run && ctick && ((pre_q & pre_mask[14:0]) == pre_mask[14:0]);

   // ----------------------------------------------------------------
   // Tick counter, wrap and match
   // ----------------------------------------------------------------
   wire at_wrap = tick_q == wrap_q;
   wire wrap_evt = cnt_step && at_wrap;
   wire match_evt = cnt_step && tick_q == match_q;
   wire clr_flags = wr && addr == `RTCP_OFS_FLAGS;

   always @(posedge clk) begin
      if (!nrst) begin
         pre_q <= 15'h0000;
         tick_q <= `RTCP_TICK_RST;
         wrap_q <= `RTCP_WRAP_RST;
         match_q <= `RTCP_MATCH_RST;
         wrap_flag_q <= 1'b0;
         match_flag_q <= 1'b0;
      end else begin
         if (ctick && cnt_run) begin
            pre_q <= pre_q + 15'h0001;
         end
         if (tick_apply) begin
            tick_q <= tick_sw_q;
         end else if (wrap_evt) begin
            tick_q <= 16'h0000;
         end else if (cnt_step) begin
            tick_q <= tick_q + 16'h0001;
         end
         if (wrap_apply) begin
            wrap_q <= wrap_sw_q;
         end
         if (match_apply) begin
            match_q <= match_sw_q;
         end
         // Hardware set wins over a same-cycle software clear.
         wrap_flag_q <= wrap_evt | (wrap_flag_q & ~(clr_flags & wdata[0]));
         match_flag_q <= match_evt | (match_flag_q & ~(clr_flags & wdata[1]));
      end
   end

   // ----------------------------------------------------------------
   // Periodic timer
   // ----------------------------------------------------------------
   reg [14:0] pit_q;
   wire [3:0] pit_code = pctrl_q[`RTCP_PCTRL_PER_LSB +: 4];
   wire pit_on = pctrl_q[0];
   wire pit_run = pit_on && (periodic_debug_q || !debug_halt);
   wire [15:0] pit_mask = (16'h0004 << (pit_code - 4'h1)) - 16'h0001;
   wire pit_valid = pit_code != `RTCP_PER_OFF && pit_code != `RTCP_PER_RSVD;
   wire pit_evt = pit_run && ctick && pit_valid
                  && ((pit_q & pit_mask[14:0]) == pit_mask[14:0]);
   wire clr_pflag = wr && addr == `RTCP_OFS_PFLAG && wdata[0];

   always @(posedge clk) begin
      if (!nrst) begin
         pit_q <= 15'h0000;
         periodic_flag_q <= 1'b0;
      end else begin
         if (!pit_on) begin
            pit_q <= 15'h0000;
         end else if (pit_run && ctick) begin
            pit_q <= pit_q + 15'h0001;
         end
         periodic_flag_q <= pit_evt | (periodic_flag_q & ~clr_pflag);
      end
   end

   assign periodic_irq = periodic_flag_q & periodic_irq_enable_q;
   assign wrap_irq_flag = wrap_flag_q;
   assign match_irq_flag = match_flag_q;

   // ----------------------------------------------------------------
   // Software-side registers and synchronization tracking
   // ----------------------------------------------------------------
   // Software copies live here; tick, wrap, match and both control values reach the counter side
   // only through their trackers, so writing them never disturbs a count in flight.
   always @(posedge clk) begin
      if (!nrst) begin
         ctrl_q <= 8'h00;
         ctrl_act_q <= 8'h00;
         halt_override_q <= 1'b0;
         source_choice_q <= `RTCP_SRC_FAST;
         tick_sw_q <= `RTCP_TICK_RST;
         wrap_sw_q <= `RTCP_WRAP_RST;
         match_sw_q <= `RTCP_MATCH_RST;
         pctrl_sw_q <= 8'h00;
         pctrl_q <= 8'h00;
         periodic_irq_enable_q <= 1'b0;
         periodic_debug_q <= 1'b0;
      end else begin
         if (wr && addr == `RTCP_OFS_DBG) halt_override_q <= wdata[0];
         if (wr && addr == `RTCP_OFS_CLOCK_SOURCE_SELECT) source_choice_q <= wdata[1:0];
         if (wr && addr == `RTCP_OFS_PIEN) periodic_irq_enable_q <= wdata[0];
         if (wr && addr == `RTCP_OFS_PDBG) periodic_debug_q <= wdata[0];
         if (wr && addr == `RTCP_OFS_TICK_L) tick_sw_q[7:0] <= wdata;
         if (wr && addr == `RTCP_OFS_TICK_H) tick_sw_q[15:8] <= wdata;
         if (wr && addr == `RTCP_OFS_WRAP_L) wrap_sw_q[7:0] <= wdata;
         if (wr && addr == `RTCP_OFS_WRAP_H) wrap_sw_q[15:8] <= wdata;
         if (wr && addr == `RTCP_OFS_MATCH_L) match_sw_q[7:0] <= wdata;
         if (wr && addr == `RTCP_OFS_MATCH_H) match_sw_q[15:8] <= wdata;
         if (wr_pctrl) pctrl_sw_q <= {1'b0, wdata[6:3], 2'b00, wdata[0]};
         if (wr_ctrl) ctrl_q <= {wdata[7:3], 2'b00, wdata[0]};
         if (pctrl_apply) pctrl_q <= pctrl_sw_q;
         if (ctrl_apply) ctrl_act_q <= ctrl_q;
      end
   end

   // ----------------------------------------------------------------
   // Synchronization trackers
   // ----------------------------------------------------------------
   // Both bytes of a 16-bit value share one tracker, so the pair lands
   // together on one tick; the cost is that a byte write restarts the wait.
   rtcp_sync_pend #(
      .LOAD(`RTCP_SYNC_TICKS)
   ) u_tick_pend (
      .clk(clk),
      .nrst(nrst),
      .load(wr_tick),
      .tick(ctick),
      .apply(tick_apply),
      .busy(tick_busy)
   );

   rtcp_sync_pend #(
      .LOAD(`RTCP_SYNC_TICKS)
   ) u_wrap_pend (
      .clk(clk),
      .nrst(nrst),
      .load(wr_wrap),
      .tick(ctick),
      .apply(wrap_apply),
      .busy(wrap_busy)
   );

   rtcp_sync_pend #(
      .LOAD(`RTCP_SYNC_TICKS)
   ) u_match_pend (
      .clk(clk),
      .nrst(nrst),
      .load(wr_match),
      .tick(ctick),
      .apply(match_apply),
      .busy(match_busy)
   );

   rtcp_sync_pend #(
      .LOAD(`RTCP_SYNC_TICKS)
   ) u_pctrl_pend (
      .clk(clk),
      .nrst(nrst),
      .load(wr_pctrl),
      .tick(ctick),
      .apply(pctrl_apply),
      .busy(pctrl_busy)
   );

   rtcp_sync_pend #(
      .LOAD(`RTCP_SYNC_TICKS)
   ) u_ctrl_pend (
      .clk(clk),
      .nrst(nrst),
      .load(wr_ctrl),
      .tick(ctick),
      .apply(ctrl_apply),
      .busy(ctrl_busy)
   );

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Tick reads back the live counter-side value so software sees
   // the running count; wrap reads its software copy; unmapped offsets read zero.
   always @(posedge clk) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `RTCP_OFS_CTRL: rdata <= ctrl_q;
            `RTCP_OFS_STATUS: rdata <= {4'h0, match_busy, wrap_busy, tick_busy, ctrl_busy};
            `RTCP_OFS_FLAGS: rdata <= {6'h00, match_flag_q, wrap_flag_q};
            `RTCP_OFS_DBG: rdata <= {7'h00, halt_override_q};
            `RTCP_OFS_CLOCK_SOURCE_SELECT: rdata <= {6'h00, source_choice_q};
            `RTCP_OFS_TICK_L: rdata <= tick_q[7:0];
            `RTCP_OFS_TICK_H: rdata <= tick_q[15:8];
            `RTCP_OFS_WRAP_L: rdata <= wrap_sw_q[7:0];
            `RTCP_OFS_WRAP_H: rdata <= wrap_sw_q[15:8];
            `RTCP_OFS_MATCH_L: rdata <= match_sw_q[7:0];
            `RTCP_OFS_MATCH_H: rdata <= match_sw_q[15:8];
            `RTCP_OFS_PCTRL: rdata <= pctrl_sw_q;
            `RTCP_OFS_PSTAT: rdata <= {7'h00, pctrl_busy};
            `RTCP_OFS_PIEN: rdata <= {7'h00, periodic_irq_enable_q};
            `RTCP_OFS_PFLAG: rdata <= {7'h00, periodic_flag_q};
            `RTCP_OFS_PDBG: rdata <= {7'h00, periodic_debug_q};
            default: rdata <= 8'h00;
         endcase
      end
   end

endmodule

// ----------------------------------------------------------------
// Synchronization tracker
// ----------------------------------------------------------------
// Counts the counter-domain ticks that a written value still has to wait.
// A write loads the full latency and each tick counts it down; the value
// lands on the tick that empties the count. A write while busy restarts
// the wait, so a value is never applied half updated. The wait is in
// counter ticks, not clk cycles, so a stopped source leaves busy high.
module rtcp_sync_pend #(
   parameter [1:0] LOAD = `RTCP_SYNC_TICKS
) (
   input wire clk,
   input wire nrst,
   input wire load,
   input wire tick,
   output wire apply,
   output wire busy
);
   reg [1:0] pend_q;
   reg [1:0] pend_d;

   assign apply = tick && pend_q == 2'h1;
   assign busy = pend_q != 2'h0;

   // A new write takes precedence over a tick in the same cycle.
   always @* begin
      if (load) begin
         pend_d = LOAD;
      end else if (tick && busy) begin
         pend_d = pend_q - 2'h1;
      end else begin
         pend_d = pend_q;
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         pend_q <= 2'h0;
      end else begin
         pend_q <= pend_d;
      end
   end
endmodule

// *** sim/rtcp_counter_props.sv ***
// Purpose: Port-level properties of the counter block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every rtcp_counter instance.
`timescale 1ns/1ps
`include "rtcp_consts.vh"
module rtcp_props (
   input wire clk,
   input wire nrst,
   input wire [4:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire debug_halt,
   input wire periodic_irq,
   input wire wrap_irq_flag,
   input wire match_irq_flag
);
   reg pien_q;
   reg dbg_q;
   reg pdbg_q;
   reg [3:0] halt_q;
   // Halt age saturates at eight, so an edge already in flight cannot trip the quiet checks.
   always @(posedge clk) begin
      if (!nrst) begin
         pien_q <= 1'b0;
         dbg_q <= 1'b0;
         pdbg_q <= 1'b0;
         halt_q <= 4'h0;
      end else begin
         if (wr && addr == `RTCP_OFS_PIEN) pien_q <= wdata[0];
         if (wr && addr == `RTCP_OFS_DBG) dbg_q <= wdata[0];
         if (wr && addr == `RTCP_OFS_PDBG) pdbg_q <= wdata[0];
         halt_q <= !debug_halt ? 4'h0 : halt_q + {3'h0, halt_q != 4'h8};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wr_rd(a, b);
      wr && addr == a ##[1:4] rd && addr == b;
   endsequence
   a_pctrl_busy: assert property (s_wr_rd(`RTCP_OFS_PCTRL, `RTCP_OFS_PSTAT) |=> rdata[0])
      else $error("periodic busy missing after control write");
   a_tick_busy: assert property (s_wr_rd(`RTCP_OFS_TICK_L, `RTCP_OFS_STATUS) |=> rdata[1])
      else $error("tick busy missing after write");
   a_match_busy: assert property (s_wr_rd(`RTCP_OFS_MATCH_H, `RTCP_OFS_STATUS) |=> rdata[3])
      else $error("match busy missing after write");
   a_pstat_clean: assert property (rd && addr == `RTCP_OFS_PSTAT |=> rdata[7:1] == 7'h00)
      else $error("periodic status upper bits set");
   a_irq_gated: assert property (periodic_irq |-> pien_q)
      else $error("periodic request without enable");
   a_wrap_hold: assert property ($fell(wrap_irq_flag) |->
      !$past(nrst) || $past(wr && addr == `RTCP_OFS_FLAGS && wdata[0]))
      else $error("wrap flag cleared without write");
   a_match_hold: assert property ($fell(match_irq_flag) |->
      !$past(nrst) || $past(wr && addr == `RTCP_OFS_FLAGS && wdata[1]))
      else $error("match flag cleared without write");
   a_halt_quiet: assert property (halt_q == 4'h8 && !dbg_q |->
      !$rose(wrap_irq_flag) && !$rose(match_irq_flag))
      else $error("counter event during debug halt");
   a_pit_quiet: assert property (halt_q == 4'h8 && !pdbg_q && !$past(wr) |->
      !$rose(periodic_irq))
      else $error("periodic event during debug halt");
endmodule
bind rtcp_counter rtcp_props u_rtcp_props (.clk(clk), .nrst(nrst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .debug_halt(debug_halt),
   .periodic_irq(periodic_irq), .wrap_irq_flag(wrap_irq_flag), .match_irq_flag(match_irq_flag));

// *** sim/rtcp_counter_tb.sv ***
// Purpose: Self-checking bench of the counter block.
// Assumes: Source edges far slower than clk.
// Notes: Sync timing is seen through busy bits and the live count.
`timescale 1ns/1ps
`include "rtcp_consts.vh"
module rtcp_counter_tb;
   reg clk;
   reg nrst;
   reg wr;
   reg rd;
   reg debug_halt;
   reg [4:0] addr;
   reg [7:0] wdata;
   reg [2:0] pins;
   wire [7:0] rdata;
   wire periodic_irq;
   wire wrap_irq_flag;
   wire match_irq_flag;
   integer num_errors;
   integer comparisons;
   integer i;
   rtcp_counter u_rtcp_counter (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .debug_halt(debug_halt),
      .low_power_oscillator(pins[0]), .crystal_input_pin(pins[1]),
      .external_pin_source(pins[2]), .periodic_irq(periodic_irq),
      .wrap_irq_flag(wrap_irq_flag), .match_irq_flag(match_irq_flag));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wreg(input [4:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rchk(input [4:0] a, input [7:0] exp);
      begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         chk(rdata, exp);
      end
   endtask
   // Each source edge lasts several clocks so the sampler cannot miss it.
   task ticks(input [2:0] p, input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            repeat (3) @(posedge clk);
            pins <= p;
            repeat (3) @(posedge clk);
            pins <= 3'h0;
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("errors=%0d comparisons=%0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      num_errors = num_errors + 1;
      tally_and_finish;
   end
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      debug_halt = 1'b0;
      addr = 5'h00;
      wdata = 8'h00;
      pins = 3'h0;
      num_errors = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 22; i = i + 1)
         rchk(i[4:0], (i == 10 || i == 11) ? 8'hFF : 8'h00);
      // A foreign pin, or too few oscillator edges on the slow source, must not finish the sync; the chosen one must.
      for (i = 0; i < 4; i = i + 1) begin
         wreg(`RTCP_OFS_CLOCK_SOURCE_SELECT, i[7:0]);
         rchk(`RTCP_OFS_CLOCK_SOURCE_SELECT, i[7:0]);
         wreg(`RTCP_OFS_MATCH_H, 8'h10 + i[7:0]);
         ticks((i == 1 || i == 3) ? 3'h1 : 3'h4, 3);
         rchk(`RTCP_OFS_STATUS, 8'h08);
         ticks((i < 2) ? 3'h1 : ((i == 2) ? 3'h2 : 3'h4), (i == 1) ? 70 : 3);
         rchk(`RTCP_OFS_STATUS, 8'h00);
         rchk(`RTCP_OFS_MATCH_H, 8'h10 + i[7:0]);
      end
      wreg(`RTCP_OFS_CLOCK_SOURCE_SELECT, 8'h00);
      wreg(`RTCP_OFS_MATCH_H, 8'h00);
      wreg(`RTCP_OFS_TICK_L, 8'h5A);
      rchk(`RTCP_OFS_STATUS, 8'h0A);
      ticks(3'h1, 1);
      rchk(`RTCP_OFS_TICK_L, 8'h00);
      ticks(3'h1, 1);
      rchk(`RTCP_OFS_TICK_L, 8'h5A);
      wreg(`RTCP_OFS_TICK_L, 8'h00);
      wreg(`RTCP_OFS_WRAP_L, 8'h04);
      wreg(`RTCP_OFS_WRAP_H, 8'h00);
      rchk(`RTCP_OFS_STATUS, 8'h06);
      wreg(`RTCP_OFS_MATCH_L, 8'h02);
      wreg(`RTCP_OFS_CTRL, 8'h01);
      wreg(`RTCP_OFS_PCTRL, 8'h09);
      rchk(`RTCP_OFS_PSTAT, 8'h01);
      wreg(`RTCP_OFS_PIEN, 8'h01);
      ticks(3'h1, 14);
      rchk(`RTCP_OFS_WRAP_L, 8'h04);
      rchk(`RTCP_OFS_FLAGS, 8'h03);
      chk({6'h00, match_irq_flag, wrap_irq_flag}, 8'h03);
      rchk(`RTCP_OFS_PFLAG, 8'h01);
      chk({7'h00, periodic_irq}, 8'h01);
      wreg(`RTCP_OFS_PIEN, 8'h00);
      #1;
      chk({7'h00, periodic_irq}, 8'h00);
      wreg(`RTCP_OFS_PIEN, 8'h01);
      debug_halt <= 1'b1;
      ticks(3'h1, 1);
      wreg(`RTCP_OFS_FLAGS, 8'h03);
      wreg(`RTCP_OFS_PFLAG, 8'h01);
      rchk(`RTCP_OFS_FLAGS, 8'h00);
      rchk(`RTCP_OFS_PFLAG, 8'h00);
      ticks(3'h1, 12);
      rchk(`RTCP_OFS_FLAGS, 8'h00);
      rchk(`RTCP_OFS_PFLAG, 8'h00);
      wreg(`RTCP_OFS_DBG, 8'h01);
      wreg(`RTCP_OFS_PDBG, 8'h01);
      ticks(3'h1, 12);
      rchk(`RTCP_OFS_FLAGS, 8'h03);
      rchk(`RTCP_OFS_PFLAG, 8'h01);
      debug_halt <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
         wreg(`RTCP_OFS_PCTRL, (i == 2) ? 8'h11 : i[7:0]);
         ticks(3'h1, 3);
         wreg(`RTCP_OFS_PFLAG, 8'h01);
         ticks(3'h1, 12);
         rchk(`RTCP_OFS_PFLAG, (i == 2) ? 8'h01 : 8'h00);
      end
      // Prescaler by two: eight counter ticks advance the count by four.
      rchk(`RTCP_OFS_STATUS, 8'h00);
      wreg(`RTCP_OFS_WRAP_H, 8'h01);
      wreg(`RTCP_OFS_CTRL, 8'h09);
      wreg(`RTCP_OFS_TICK_L, 8'h00);
      ticks(3'h1, 2);
      rchk(`RTCP_OFS_STATUS, 8'h00);
      ticks(3'h1, 8);
      rchk(`RTCP_OFS_TICK_L, 8'h04);
      rchk(`RTCP_OFS_TICK_H, 8'h00);
      tally_and_finish;
   end
endmodule
